// ### design/isq_pkg.sv
// Purpose: shared constants and types of the instruction sequencer
// Assumes: 13-bit program counter, 16-bit instruction words
// Notes: data memory address of the pc low byte is fixed at 06h
package isq_pkg;
    localparam int PC_W = 13;
    localparam int IW_W = 16;
    localparam int DA_W = 8;
    localparam int DW_W = 8;
    localparam int PAGE_LSB = 8;
    localparam int PH_N = 4;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [PC_W-1:0] VEC_EXT = 13'h0004;
    localparam logic [PC_W-1:0] VEC_T0 = 13'h0008;
    localparam logic [PC_W-1:0] VEC_T1 = 13'h000c;
    localparam logic [DA_W-1:0] PCL_ADDR = 8'h06;
    localparam logic [PH_N-1:0] PH_FIRST = 4'h1;
    localparam int PH_LAST = 3;
    // wake-up delay, in system clock periods
    localparam int STARTUP_PERIODS = 1024;
    localparam int STARTUP_CYC = STARTUP_PERIODS;
    localparam int ST_CNT_W = 11;
    localparam int IRQ_EXT = 0;
    localparam int IRQ_T0 = 1;
    localparam int IRQ_T1 = 2;
    localparam int IRQ_N = 3;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_HALT = 2'b01,
        ST_START = 2'b11
    } isq_state_t;

    // control request from the execute stage, valid at the last phase
    typedef struct packed {
        logic jump;
        logic call;
        logic ret;
        logic reti;
        logic skip;
        logic halt;
        logic [PC_W-1:0] target;
    } isq_ctrl_t;

    typedef struct packed {
        logic [DA_W-1:0] addr;
        logic [DW_W-1:0] wdata;
        logic wr;
        logic rd;
    } isq_reg_req_t;
endpackage

// ### design/isq_sequencer.sv
// Purpose: fetch and program counter sequencing of a small 8-bit core
// Assumes: program memory answers PROG_ADDR_O combinationally on PROG_DATA_I
// Notes: CTRL_I describes the instruction on INSTR_O and is sampled
// in the last phase of each instruction cycle
`timescale 1ns/10ps
`default_nettype none
module isq_sequencer #(
    parameter int STACK_DEPTH = 16
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic CHIP_RESET_IN_N_I,
    input wire logic EXT_INT_N_I,
    input wire logic TMR0_OVF_I,
    input wire logic TMR1_OVF_I,
    input wire logic [isq_pkg::IRQ_N-1:0] INT_EN_I,
    input wire logic WAKE_I,
    input wire logic RC_OPT_I,
    input wire isq_pkg::isq_ctrl_t CTRL_I,
    input wire logic [isq_pkg::IW_W-1:0] PROG_DATA_I,
    input wire isq_pkg::isq_reg_req_t REG_I,
    output logic [isq_pkg::DW_W-1:0] REG_RDATA_O,
    output logic [isq_pkg::PC_W-1:0] PROG_ADDR_O,
    output logic [isq_pkg::IW_W-1:0] INSTR_O,
    output logic INSTR_VALID_O,
    output logic [isq_pkg::PH_N-1:0] PHASE_O,
    output logic INT_ACK_O,
    output logic HALTED_O,
    output logic OSCILLATOR_OUT_O
);
    import isq_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);

    initial begin
        if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin
            $error("STACK_DEPTH must be a power of two, at least 2");
        end
    end

    function automatic logic [PC_W-1:0] pc_plus1(input logic [PC_W-1:0] v);
        pc_plus1 = v + 13'h0001;
    endfunction

    logic rst;
    logic [PH_N-1:0] phase_ff, nxt_phase;
    logic [PC_W-1:0] pc_ff, nxt_pc;
    logic [IW_W-1:0] ir_ff, nxt_ir;
    logic valid_ff, nxt_valid;
    isq_state_t state_ff, nxt_state;
    logic [ST_CNT_W-1:0] stc_ff, nxt_stc;
    logic [IRQ_N-1:0] pend_ff, nxt_pend, irq_set, irq_clr;
    logic ext_prev_ff;
    logic pclw_ff, nxt_pclw;
    logic [DW_W-1:0] pclv_ff, nxt_pclv;
    logic [DW_W-1:0] rdata_ff, nxt_rdata;
    logic ack_ff, nxt_ack;
    logic halted_ff;
    logic osc_ff, nxt_osc;
    logic [PC_W-1:0] stack_mem [STACK_DEPTH];
    logic [SP_W-1:0] sp_ff, nxt_sp;
    logic [SP_W:0] cnt_ff, nxt_cnt;
    logic push, pop;
    logic [PC_W-1:0] push_val, stack_top;
    logic cyc_end, exec, pcl_wr, pcl_due;
    logic [DW_W-1:0] pcl_val;
    logic [IRQ_N-1:0] irq_ok;
    logic [PC_W-1:0] vec;
    logic [IRQ_N-1:0] irq_onehot;
    logic sel_jmp, sel_ret, sel_pcl, sel_skip, sel_int, sel_halt, xfer;

    assign rst = RST_I | ~CHIP_RESET_IN_N_I;
    assign cyc_end = phase_ff[PH_LAST] && state_ff == ST_RUN;
    assign exec = valid_ff;
    assign pcl_wr = REG_I.wr && REG_I.addr == PCL_ADDR;
    assign pcl_due = pcl_wr | pclw_ff;
    assign pcl_val = pcl_wr ? REG_I.wdata : pclv_ff;
    assign stack_top = stack_mem[sp_ff - 1'b1];
    assign irq_set = {TMR1_OVF_I, TMR0_OVF_I, ext_prev_ff & ~EXT_INT_N_I};
    // a full stack holds the request until a return frees a level
    assign irq_ok = pend_ff & INT_EN_I & {IRQ_N{cnt_ff < STACK_DEPTH}};

    // fixed priority: external, then timer 0, then timer 1
    always_comb begin
        irq_onehot = '0;
        vec = VEC_EXT;
        if (irq_ok[IRQ_EXT]) begin
            irq_onehot[IRQ_EXT] = 1'b1;
            vec = VEC_EXT;
        end else if (irq_ok[IRQ_T0]) begin
            irq_onehot[IRQ_T0] = 1'b1;
            vec = VEC_T0;
        end else if (irq_ok[IRQ_T1]) begin
            irq_onehot[IRQ_T1] = 1'b1;
            vec = VEC_T1;
        end
    end

    // transfer selection, highest priority first
    always_comb begin
        sel_halt = cyc_end && exec && CTRL_I.halt;
        sel_jmp = cyc_end && exec && !sel_halt && (CTRL_I.jump | CTRL_I.call);
        sel_ret = cyc_end && exec && !sel_halt && !sel_jmp && (CTRL_I.ret | CTRL_I.reti);
        sel_pcl = cyc_end && !sel_halt && !sel_jmp && !sel_ret && pcl_due;
        sel_skip = cyc_end && exec && !sel_halt && !sel_jmp && !sel_ret && !sel_pcl && CTRL_I.skip;
        sel_int = cyc_end && !sel_halt && !sel_jmp && !sel_ret && !sel_pcl && !sel_skip && |irq_ok;
        xfer = sel_jmp | sel_ret | sel_pcl | sel_skip | sel_int;
    end

    always_comb begin
        nxt_phase = {phase_ff[PH_N-2:0], phase_ff[PH_N-1]};
        nxt_pc = pc_ff;
        nxt_ir = ir_ff;
        nxt_valid = valid_ff;
        nxt_state = state_ff;
        nxt_stc = stc_ff;
        irq_clr = '0;
        nxt_ack = 1'b0;
        nxt_pclw = pclw_ff | pcl_wr;
        nxt_pclv = pcl_val;
        push = 1'b0;
        pop = 1'b0;
        push_val = pc_ff;
        // read is side-effect free, answered one cycle later
        nxt_rdata = '0;
        if (REG_I.rd && REG_I.addr == PCL_ADDR) begin
            nxt_rdata = pc_ff[DW_W-1:0];
        end
        case (state_ff)
            ST_RUN: begin
                if (cyc_end) begin
                    // fetch next word while ir executes
                    nxt_ir = PROG_DATA_I;
                    nxt_valid = 1'b1;
                    nxt_pc = pc_plus1(pc_ff);
                    if (sel_halt) begin
                        // prefetched word is fetched again after wake-up
                        nxt_pc = pc_ff;
                        nxt_valid = 1'b0;
                        nxt_state = ST_HALT;
                    end else if (sel_jmp) begin
                        nxt_pc = CTRL_I.target;
                        push = CTRL_I.call;
                    end else if (sel_ret) begin
                        nxt_pc = stack_top;
                        pop = 1'b1;
                    end else if (sel_pcl) begin
                        nxt_pc = {pc_ff[PC_W-1:PAGE_LSB], pcl_val};
                        nxt_pclw = 1'b0;
                    end else if (sel_int) begin
                        // discarded prefetch address is the return point
                        nxt_pc = vec;
                        push = 1'b1;
                        irq_clr = irq_onehot;
                        nxt_ack = 1'b1;
                    end
                    if (xfer) begin
                        nxt_valid = 1'b0;
                    end
                end
            end
            ST_HALT: begin
                if (WAKE_I || |pend_ff) begin
                    nxt_state = ST_START;
                    nxt_stc = '0;
                end
            end
            ST_START: begin
                nxt_stc = stc_ff + 11'h001;
                if (stc_ff == ST_CNT_W'(STARTUP_CYC - 1)) begin
                    nxt_state = ST_RUN;
                    nxt_phase = PH_FIRST;
                end
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
        // taken from the last two phases so the wake-up restart stays aligned
        nxt_osc = RC_OPT_I & (nxt_phase[2] | nxt_phase[3]);
        // a request arriving with its clear is kept
        nxt_pend = (pend_ff & ~irq_clr) | irq_set;
        nxt_sp = sp_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            // overflow overwrites the oldest return address
            nxt_sp = sp_ff + 1'b1;
            if (cnt_ff < STACK_DEPTH) begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end else if (pop) begin
            nxt_sp = sp_ff - 1'b1;
            if (cnt_ff != '0) begin
                nxt_cnt = cnt_ff - 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (push) begin
            stack_mem[sp_ff] <= push_val;
        end
        if (rst) begin
            phase_ff <= PH_FIRST;
            pc_ff <= PC_RESET;
            ir_ff <= '0;
            valid_ff <= 1'b0;
            state_ff <= ST_RUN;
            stc_ff <= '0;
            pend_ff <= '0;
            ext_prev_ff <= 1'b1;
            pclw_ff <= 1'b0;
            pclv_ff <= '0;
            rdata_ff <= '0;
            ack_ff <= 1'b0;
            halted_ff <= 1'b0;
            osc_ff <= 1'b0;
            sp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            phase_ff <= nxt_phase;
            pc_ff <= nxt_pc;
            ir_ff <= nxt_ir;
            valid_ff <= nxt_valid;
            state_ff <= nxt_state;
            stc_ff <= nxt_stc;
            pend_ff <= nxt_pend;
            ext_prev_ff <= EXT_INT_N_I;
            pclw_ff <= nxt_pclw;
            pclv_ff <= nxt_pclv;
            rdata_ff <= nxt_rdata;
            ack_ff <= nxt_ack;
            halted_ff <= nxt_state != ST_RUN;
            osc_ff <= nxt_osc;
            sp_ff <= nxt_sp;
            cnt_ff <= nxt_cnt;
        end
    end

    assign REG_RDATA_O = rdata_ff;
    assign PROG_ADDR_O = pc_ff;
    assign INSTR_O = ir_ff;
    assign INSTR_VALID_O = valid_ff;
    assign PHASE_O = phase_ff;
    assign INT_ACK_O = ack_ff;
    assign HALTED_O = halted_ff;
    assign OSCILLATOR_OUT_O = osc_ff;

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (rst);

    AST_PHASE_ROTATE: assert property (state_ff == ST_RUN && phase_ff[0] |=> phase_ff[1] ##1 phase_ff[2] ##1 phase_ff[3])
        else $error("phase sequence broken");
    AST_PC_HOLD: assert property (!phase_ff[PH_LAST] && state_ff == ST_RUN |=> $stable(pc_ff) && $stable(ir_ff))
        else $error("pc or ir moved inside a cycle");
    AST_PC_INC: assert property (cyc_end && !xfer && !sel_halt |=> pc_ff == pc_plus1($past(pc_ff)) && valid_ff)
        else $error("pc did not advance by one");
    AST_DUMMY: assert property (xfer |=> !valid_ff [*4])
        else $error("no dummy cycle after transfer");
    AST_SKIP_PC: assert property (sel_skip |=> pc_ff == pc_plus1($past(pc_ff)) ##4 pc_ff == $past(pc_ff, 5) + 13'h0002)
        else $error("skip did not land two beyond");
    AST_PCL_JUMP: assert property (sel_pcl |=> pc_ff == {$past(pc_ff[PC_W-1:PAGE_LSB]), $past(pcl_val)})
        else $error("low byte jump left the page");
    AST_RESET_PC: assert property (disable iff (1'b0) rst |=> pc_ff == PC_RESET && !valid_ff)
        else $error("reset did not clear pc");
    AST_INT_VEC: assert property (sel_int |=> pc_ff == $past(vec) && INT_ACK_O)
        else $error("wrong interrupt vector");
    AST_RET_POP: assert property (sel_ret |=> pc_ff == $past(stack_top))
        else $error("return address not restored");
    AST_EXT_EDGE: assert property (!pend_ff[IRQ_EXT] && !ext_prev_ff && !irq_set[IRQ_EXT] |=> !pend_ff[IRQ_EXT])
        else $error("level raised a request");
    AST_STARTUP: assert property (state_ff == ST_HALT && nxt_state == ST_START |=> state_ff == ST_START && stc_ff == '0)
        else $error("start-up timer not restarted");
    AST_PCL_READ: assert property (REG_I.rd && REG_I.addr == PCL_ADDR |=> REG_RDATA_O == $past(pc_ff[DW_W-1:0]))
        else $error("low byte read wrong");
    AST_OSC: assert property ($past(RC_OPT_I) |-> OSCILLATOR_OUT_O == (phase_ff[2] | phase_ff[3]))
        else $error("oscillator output not quarter rate");
    AST_OSC_OFF: assert property (!$past(RC_OPT_I) |-> !OSCILLATOR_OUT_O)
        else $error("oscillator output active without rc option");
    AST_EXT_SET: assert property (ext_prev_ff && !EXT_INT_N_I |=> pend_ff[IRQ_EXT])
        else $error("falling edge did not raise a request");
    AST_HALT_HOLD: assert property (sel_halt |=> HALTED_O && !valid_ff && pc_ff == $past(pc_ff))
        else $error("halt did not freeze the pc");

    COV_SKIP: cover property (sel_skip);
    COV_INT: cover property (sel_int ##[1:40] sel_ret);
    COV_PCL: cover property (sel_pcl);
    COV_WAKE: cover property (state_ff == ST_START ##1 state_ff == ST_RUN);
endmodule
`default_nettype wire

// ### verification/isq_prog_mem.sv
// Purpose: program memory model facing the sequencer fetch port
// Assumes: combinational read of one 16-bit word per address
// Notes: word content is a fixed function of its address
`timescale 1ns/10ps
`default_nettype none
module isq_prog_mem (
    input wire logic [isq_pkg::PC_W-1:0] addr_i,
    output logic [isq_pkg::IW_W-1:0] data_o
);
    import isq_pkg::*;
    // full 8192-word space; address in the word exposes fetch slips
    assign data_o = {3'b101, addr_i};
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Purpose: self-checking bench of the instruction sequencer
// Assumes: control requests are given in the last phase
// Notes: row table covers plain fetch, jumps, skip, call and return
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import isq_pkg::*;
    typedef struct packed {
        isq_ctrl_t c;
        logic [PC_W-1:0] pc;
        logic v;
    } isq_row_t;
    logic clk = 0, rst = 1, res_n = 1, ext_n = 1, t0 = 0, t1 = 0, wake = 0, rc = 1;
    logic [IRQ_N-1:0] int_en = 3'h7;
    isq_ctrl_t ctrl = '0;
    isq_reg_req_t req = '0;
    logic [IW_W-1:0] pdata, instr;
    logic [PC_W-1:0] paddr, epc, ret_pc;
    logic [PC_W-1:0] vec[3] = '{VEC_EXT, VEC_T0, VEC_T1};
    logic [DW_W-1:0] rdata;
    logic [PH_N-1:0] phase, pph;
    logic ivalid, ack, halted, osc;
    int mismatches = 0, total_checks = 0, cycles = 0, n;
    isq_row_t rows[12] = '{'{19'h0, 13'h001, 1'b1}, '{19'h0, 13'h002, 1'b1}, '{19'h40155, 13'h155, 1'b0},
        '{19'h0, 13'h156, 1'b1}, '{19'h04000, 13'h157, 1'b0}, '{19'h0, 13'h158, 1'b1},
        '{19'h21a00, 13'h1a00, 1'b0}, '{19'h0, 13'h1a01, 1'b1}, '{19'h10000, 13'h158, 1'b0},
        '{19'h0, 13'h159, 1'b1}, '{19'h40100, 13'h100, 1'b0}, '{19'h400aa, 13'h101, 1'b1}};

    isq_sequencer #(.STACK_DEPTH(16)) u_isq_sequencer (.SYS_CLK_I(clk), .RST_I(rst),
        .CHIP_RESET_IN_N_I(res_n), .EXT_INT_N_I(ext_n), .TMR0_OVF_I(t0), .TMR1_OVF_I(t1),
        .INT_EN_I(int_en), .WAKE_I(wake), .RC_OPT_I(rc), .CTRL_I(ctrl), .PROG_DATA_I(pdata),
        .REG_I(req), .REG_RDATA_O(rdata), .PROG_ADDR_O(paddr), .INSTR_O(instr),
        .INSTR_VALID_O(ivalid), .PHASE_O(phase), .INT_ACK_O(ack), .HALTED_O(halted),
        .OSCILLATOR_OUT_O(osc));
    isq_prog_mem u_isq_prog_mem (.addr_i(paddr), .data_o(pdata));

    always #20 clk = ~clk;

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // whole run takes about 1200 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // request in the cycle before the taking edge, released right after it
    task automatic step(isq_ctrl_t c);
        do @(posedge clk); while (phase !== 4'h4);
        ctrl <= c;
        @(posedge clk);
        ctrl <= '0;
        #1;
    endtask

    task automatic expect_pc(logic [PC_W-1:0] pc, logic v);
        chk("pc", 16'(pc), 16'(paddr));
        chk("valid", 16'(v), 16'(ivalid));
        if (v)
            chk("instr", {3'b101, pc - 13'h1}, instr);
        epc = pc;
    endtask

    // only one register access fits between two steps
    task automatic reg_wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '0;
    endtask

    task automatic reg_rd(logic [7:0] a, logic [7:0] exp);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        #1;
        chk("rdata", 16'(exp), 16'(rdata));
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("pc", 16'(PC_RESET), 16'(paddr));
        chk("phase", 16'(PH_FIRST), 16'(phase));
        for (int i = 0; i < 12; i++) begin
            step(rows[i].c);
            expect_pc(rows[i].pc, rows[i].v);
        end
        reg_wr(8'h07, 8'hff);
        step('0);
        expect_pc(epc + 13'h1, 1'b1);
        reg_wr(PCL_ADDR, 8'h3c);
        step('0);
        expect_pc({epc[12:8], 8'h3c}, 1'b0);
        step('0);
        expect_pc(epc + 13'h1, 1'b1);
        reg_rd(PCL_ADDR, epc[7:0]);
        step('0);
        expect_pc(epc + 13'h1, 1'b1);
        reg_rd(8'h05, 8'h00);
        step('0);
        expect_pc(epc + 13'h1, 1'b1);
        // ext pin stays low afterwards: a level must not request again
        for (int i = 0; i < 3; i++) begin
            ret_pc = epc;
            @(posedge clk);
            if (i == 0)
                ext_n <= 1'b0;
            else if (i == 1)
                t0 <= 1'b1;
            else
                t1 <= 1'b1;
            @(posedge clk);
            t0 <= 1'b0;
            t1 <= 1'b0;
            step('0);
            expect_pc(vec[i], 1'b0);
            n = (ack === 1'b1);
            @(posedge clk);
            #1;
            n += (ack === 1'b1);
            chk("ack", 16'h1, 16'(n));
            step('0);
            expect_pc(epc + 13'h1, 1'b1);
            step(19'h08000);
            expect_pc(ret_pc, 1'b0);
            step('0);
            expect_pc(epc + 13'h1, 1'b1);
        end
        // masked timer request waits until its enable returns
        @(posedge clk);
        int_en <= 3'h5;
        t0 <= 1'b1;
        @(posedge clk);
        t0 <= 1'b0;
        step('0);
        expect_pc(epc + 13'h1, 1'b1);
        ret_pc = epc;
        @(posedge clk);
        int_en <= 3'h7;
        step('0);
        expect_pc(VEC_T0, 1'b0);
        step('0);
        expect_pc(epc + 13'h1, 1'b1);
        step(19'h08000);
        expect_pc(ret_pc, 1'b0);
        step('0);
        expect_pc(epc + 13'h1, 1'b1);
        step(19'h02000);
        chk("halted", 16'h1, 16'(halted));
        @(posedge clk);
        wake <= 1'b1;
        ext_n <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        n = 0;
        while (halted !== 1'b0 && n < 1100) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("wake", 16'h1, 16'(n >= STARTUP_CYC - 1 && n <= STARTUP_CYC + 1));
        @(posedge clk);
        res_n <= 1'b0;
        @(posedge clk);
        res_n <= 1'b1;
        #1;
        chk("pc", 16'(PC_RESET), 16'(paddr));
        chk("valid", 16'h0, 16'(ivalid));
        n = 0;
        repeat (8) begin
            pph = phase;
            @(posedge clk);
            #1;
            chk("phase", 16'({pph[2:0], pph[3]}), 16'(phase));
            n += (osc === 1'b1);
        end
        chk("osc", 16'h4, 16'(n));
        @(posedge clk);
        rc <= 1'b0;
        n = 0;
        repeat (4) begin
            @(posedge clk);
            #1;
            n += (osc === 1'b1);
        end
        chk("osc_off", 16'h0, 16'(n));
        conclude();
    end
endmodule
`default_nettype wire
